// ---- pkg/srcs_cfg.svh ----
// Register offsets, field positions, reset values and timing for the SYSREF capture block.
// Included by the capture core, the top module and the testbench; definitions only.
`ifndef SRCS_CFG_SVH
`define SRCS_CFG_SVH
// Printed offsets are not all multiples of four: they are register indices
`define SRCS_IDX_CTRL1      12'h0120
`define SRCS_IDX_CTRL3      12'h0122
`define SRCS_IDX_TSDLY      12'h0123
`define SRCS_IDX_STAT1      12'h0128
`define SRCS_IDX_STAT2      12'h0129
`define SRCS_IDX_STAT3      12'h012A
`define SRCS_IDX_SYNCM      12'h01FF
`define SRCS_IDX_IRQST      12'h0130
`define SRCS_IDX_IRQMSK     12'h0131
`define SRCS_BIT_FLAGRST    6
`define SRCS_LSB_MODE       1
`define SRCS_LSB_NEGWIN     2
`define SRCS_LSB_HOLD       4
`define SRCS_RST_CTRL1      8'h00
`define SRCS_RST_CTRL3      8'h00
`define SRCS_RST_TSDLY      7'h00
`define SRCS_RST_SYNCM      1'b0
`define SRCS_CNT_WRAP       8'hFF
`define SRCS_DIV_PHASES     16
`endif

// ---- pkg/srcs_pkg.sv ----
// Types shared by the SYSREF capture block.
// Constants live in srcs_cfg.svh.
package srcs_pkg;
   typedef enum logic [1:0] {
      SRCS_MODE_OFF    = 2'b00,
      SRCS_MODE_CONT   = 2'b01,
      SRCS_MODE_NSHOT  = 2'b10,
      SRCS_MODE_RSV    = 2'b11
   } srcs_mode_t;
   typedef enum logic [0:0] {
      SRCS_SYNC_DIVRST = 1'b0,
      SRCS_SYNC_TSTAMP = 1'b1
   } srcs_sync_t;
endpackage

// ---- pkg/srcs_cap_if.sv ----
// Carries one capture event and its outcome between the top and the capture core.
// Single clock domain.
`timescale 1ns/1ps
interface srcs_cap_if;
   logic       event_p;
   logic       miss_p;
   logic [3:0] setup_st;
   logic [3:0] hold_st;
   logic [3:0] phase;
   modport core (output event_p, output miss_p, output setup_st, output hold_st, output phase);
   modport top  (input event_p, input miss_p, input setup_st, input hold_st, input phase);
endinterface

// ---- src/srcs_capture.sv ----
// Capture core: edge detect on synchronised SYSREF, skew window check, divider phase.
// Assumes sysref_s already passed a two-flop synchroniser.
`timescale 1ns/1ps
`include "srcs_cfg.svh"
module srcs_capture
   import srcs_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        sysref_s,
   input  wire logic        enable,
   input  wire logic [1:0]  pos_win,
   input  wire logic [1:0]  neg_win,
   input  wire logic [3:0]  div_phase,
   srcs_cap_if.core         cap
);
   typedef struct packed {
      logic       prev;
      logic       evt;
      logic       miss;
      logic [3:0] setup;
      logic [3:0] hold;
      logic [3:0] phase;
   } srcs_cst_t;
   srcs_cst_t s_q, s_d;

   // Phase counts half input-clock steps; expected capture at phase zero
   function automatic logic [3:0] srcs_margin(input logic [3:0] p);
      return p;
   endfunction

   always_comb begin
      logic [3:0] early;
      logic [3:0] late;
      early = 4'(`SRCS_DIV_PHASES) - div_phase;
      late  = srcs_margin(div_phase);
      s_d = s_q;
      s_d.prev = sysref_s;
      s_d.evt = 1'b0;
      s_d.miss = 1'b0;
      if (enable && sysref_s && !s_q.prev) begin
         s_d.phase = div_phase; // R4
         // Late capture tolerated up to pos window clocks (two half steps each)
         if (late[3:1] <= {1'b0, pos_win} && late[0] == 1'b0) begin // R1
            s_d.evt = 1'b1;
            s_d.setup = 4'h0;
            s_d.hold = 4'h0;
         end else if (early[3:1] <= {1'b0, neg_win} && early[0] == 1'b0) begin // R2
            s_d.evt = 1'b1;
            s_d.setup = 4'h0;
            s_d.hold = 4'h0;
         end else begin
            // One pulse per misaligned capture so the error event is not a level
            s_d.miss  = 1'b1; // R13
            s_d.setup = (early < late) ? early : 4'h0; // R13
            s_d.hold  = (early < late) ? 4'h0 : late; // R13
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cap.event_p  = s_q.evt;
   assign cap.miss_p   = s_q.miss;
   assign cap.setup_st = s_q.setup;
   assign cap.hold_st  = s_q.hold;
   assign cap.phase    = s_q.phase;

   property p_no_evt_when_off;
      @(posedge pclk) disable iff (!presetn) !enable |=> !cap.event_p;
   endproperty
   a_no_evt_when_off: assert property (p_no_evt_when_off) else $error("event while disabled");
endmodule // srcs_capture

// ---- src/srcs_ts_delay.sv ----
// Timestamp delay line: shifts the capture mark by 0..127 sample clocks.
// Single clock; mark enters as a one-cycle pulse.
`timescale 1ns/1ps
module srcs_ts_delay #(
   parameter int DEPTH = 128
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      mark_in,
   input  wire logic [$clog2(DEPTH)-1:0]  delay,
   output logic                           mark_out
);
   typedef struct packed {
      logic [DEPTH-1:0] line;
      logic             out;
   } srcs_dst_t;
   srcs_dst_t s_q, s_d;

   initial begin
      // The delay code indexes the whole line, so the depth must be a power of two
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be a power of two");
   end

   always_comb begin
      s_d = s_q;
      s_d.line = {s_q.line[DEPTH-2:0], mark_in};
      s_d.out = (delay == '0) ? mark_in : s_q.line[delay - 1'b1]; // R3
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign mark_out = s_q.out;
endmodule // srcs_ts_delay

// ---- src/srcs_top.sv ----
// SYSREF capture and synchronization block with APB register access.
// Assumes sysref and div_phase arrive asynchronously; dividers live outside.
// Functional notes
// R1 - Positive window codes 00..11 tolerate 0..3 late sample clocks; 00 exact
// R2 - Negative window codes 10 and 11 tolerate two and three early clocks
// R3 - Timestamp mark delayed by 0..127 sample clocks; zero means no delay
// R4 - Divider phase at capture reported in half-cycle steps, four bits
// R5 - Eight-bit event counter increments per capture and wraps after 255
// R6 - Flag-reset bit 6 of control 1 clears the event counter
// R7 - Software reads the counter only while capture mode is disabled
// R8 - Sync mode 0: each accepted event resets the clock dividers
// R9 - In sync mode 0 a forced divider phase change drops the link
// R10 - Sync mode 1: no divider reset, link and monitor undisturbed
// R11 - Timestamp mode marks the coinciding sample as an output control bit
// R12 - While flag-reset is set, setup and hold flags stay cleared
// R13 - Setup and hold status fields are read-only and show sampling margin
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "srcs_cfg.svh"
module srcs_top
   import srcs_pkg::*;
#(
   parameter int TS_DEPTH = 128
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        sysref,
   input  wire logic [3:0]  div_phase,
   output logic             div_reset,
   output logic             link_down,
   output logic             ts_ctrl_bit,
   output logic             irq
);
   import srcs_pkg::*;

   typedef struct packed {
      logic [1:0] sr_sync;
      logic [3:0] ph_sync1;
      logic [3:0] ph_sync2;
      logic [7:0] ctrl1;
      logic [3:0] win;
      logic [6:0] tsdly;
      logic       syncm;
      logic [7:0] count;
      logic [3:0] setup;
      logic [3:0] hold;
      logic [3:0] phase;
      logic [1:0] irq_st;
      logic [1:0] irq_msk;
      logic       divrst;
      logic       lnkdn;
      logic [31:0] rdata;
   } srcs_st_t;
   srcs_st_t s_q, s_d;

   srcs_cap_if cap_bus ();
   logic ts_mark;

   initial begin
      if (TS_DEPTH != 128) $error("timestamp delay field is 7 bits; depth must be 128");
   end

   // Word index from byte address; unaligned high bits ignored
   function automatic logic [11:0] srcs_idx(input logic [15:0] a);
      return a[13:2];
   endfunction

   function automatic logic srcs_mapped(input logic [11:0] i);
      return (i == `SRCS_IDX_CTRL1) || (i == `SRCS_IDX_CTRL3) || (i == `SRCS_IDX_TSDLY) ||
             (i == `SRCS_IDX_STAT1) || (i == `SRCS_IDX_STAT2) || (i == `SRCS_IDX_STAT3) ||
             (i == `SRCS_IDX_SYNCM) || (i == `SRCS_IDX_IRQST) || (i == `SRCS_IDX_IRQMSK);
   endfunction

   logic       flag_rst;
   srcs_mode_t cap_mode;
   srcs_sync_t sync_mode;
   assign flag_rst  = s_q.ctrl1[`SRCS_BIT_FLAGRST];
   assign cap_mode  = srcs_mode_t'(s_q.ctrl1[`SRCS_LSB_MODE +: 2]);
   assign sync_mode = srcs_sync_t'(s_q.syncm);

   srcs_capture u_cap (
      .pclk      (pclk),
      .presetn   (presetn),
      .sysref_s  (s_q.sr_sync[1]),
      .enable    (cap_mode != SRCS_MODE_OFF),
      .pos_win   (s_q.win[1:0]),
      .neg_win   (s_q.win[3:2]),
      .div_phase (s_q.ph_sync2),
      .cap       (cap_bus.core)
   );

   srcs_ts_delay #(.DEPTH(TS_DEPTH)) u_dly (
      .pclk     (pclk),
      .presetn  (presetn),
      .mark_in  (cap_bus.event_p && sync_mode == SRCS_SYNC_TSTAMP), // R11
      .delay    (s_q.tsdly),
      .mark_out (ts_mark)
   );

   logic wr_acc;
   logic rd_acc;
   logic [11:0] idx;
   assign idx    = srcs_idx(paddr);
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;

   always_comb begin
      s_d = s_q;
      // Two flops before any logic sees the pins
      s_d.sr_sync  = {s_q.sr_sync[0], sysref};
      s_d.ph_sync1 = div_phase;
      s_d.ph_sync2 = s_q.ph_sync1;
      s_d.divrst = 1'b0;
      s_d.lnkdn  = 1'b0;

      if (cap_bus.event_p) begin
         s_d.count = s_q.count + 8'h01; // R5
         s_d.phase = cap_bus.phase; // R4
         if (sync_mode == SRCS_SYNC_DIVRST) begin
            s_d.divrst = 1'b1; // R8
            s_d.lnkdn  = (cap_bus.phase != 4'h0); // R9
         end // R10
      end
      // Status follows each capture outcome; margins from before a flag reset never return
      if (!flag_rst && (cap_bus.event_p || cap_bus.miss_p)) begin
         s_d.setup = cap_bus.setup_st; // R13
         s_d.hold  = cap_bus.hold_st; // R13
      end

      // Events: bit0 capture, bit1 margin error
      if (wr_acc && idx == `SRCS_IDX_IRQST) begin
         s_d.irq_st = s_q.irq_st & ~pwdata[1:0];
      end
      if (cap_bus.event_p) begin
         s_d.irq_st[0] = 1'b1;
      end
      if (!flag_rst && cap_bus.miss_p) begin
         s_d.irq_st[1] = 1'b1;
      end

      if (wr_acc) begin
         if (idx == `SRCS_IDX_CTRL1) begin
            s_d.ctrl1 = {1'b0, pwdata[6], 3'b000, pwdata[2:1], 1'b0};
         end else if (idx == `SRCS_IDX_CTRL3) begin
            s_d.win = pwdata[3:0];
         end else if (idx == `SRCS_IDX_TSDLY) begin
            s_d.tsdly = pwdata[6:0];
         end else if (idx == `SRCS_IDX_SYNCM) begin
            s_d.syncm = pwdata[0];
         end else if (idx == `SRCS_IDX_IRQMSK) begin
            s_d.irq_msk = pwdata[1:0];
         end
      end

      // Flag reset holds status cleared and the counter at zero
      if (flag_rst) begin
         s_d.setup = 4'h0; // R12
         s_d.hold  = 4'h0; // R12
         s_d.count = 8'h00; // R6
      end

      // Read data registered in setup phase; counter stable only when mode off
      if (rd_acc) begin
         if (idx == `SRCS_IDX_CTRL1) begin
            s_d.rdata = {24'h00_0000, s_q.ctrl1};
         end else if (idx == `SRCS_IDX_CTRL3) begin
            s_d.rdata = {28'h000_0000, s_q.win};
         end else if (idx == `SRCS_IDX_TSDLY) begin
            s_d.rdata = {25'h000_0000, s_q.tsdly}; // R3
         end else if (idx == `SRCS_IDX_STAT1) begin
            s_d.rdata = {24'h00_0000, s_q.hold, s_q.setup}; // R13
         end else if (idx == `SRCS_IDX_STAT2) begin
            s_d.rdata = {28'h000_0000, s_q.phase}; // R4
         end else if (idx == `SRCS_IDX_STAT3) begin
            s_d.rdata = {24'h00_0000, s_q.count}; // R7
         end else if (idx == `SRCS_IDX_SYNCM) begin
            s_d.rdata = {31'h0000_0000, s_q.syncm};
         end else if (idx == `SRCS_IDX_IRQST) begin
            s_d.rdata = {30'h0000_0000, s_q.irq_st};
         end else if (idx == `SRCS_IDX_IRQMSK) begin
            s_d.rdata = {30'h0000_0000, s_q.irq_msk};
         end else begin
            s_d.rdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q         <= '0;
         s_q.ctrl1   <= `SRCS_RST_CTRL1;
         s_q.win     <= 4'h0;
         s_q.tsdly   <= `SRCS_RST_TSDLY;
         s_q.syncm   <= `SRCS_RST_SYNCM;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata      = s_q.rdata;
   assign pready      = 1'b1;
   assign pslverr     = psel && penable && !srcs_mapped(idx);
   assign div_reset   = s_q.divrst;
   assign link_down   = s_q.lnkdn;
   assign ts_ctrl_bit = ts_mark;
   assign irq         = |(s_q.irq_st & s_q.irq_msk);

   property p_count_inc;
      @(posedge pclk) disable iff (!presetn)
         (cap_bus.event_p && !flag_rst) |=> (s_q.count == $past(s_q.count) + 8'h01);
   endproperty
   a_count_inc: assert property (p_count_inc) else $error("counter did not step"); // R5

   property p_count_clr;
      @(posedge pclk) disable iff (!presetn) flag_rst |=> s_q.count == 8'h00;
   endproperty
   a_count_clr: assert property (p_count_clr) else $error("counter not cleared"); // R6

   property p_divrst;
      @(posedge pclk) disable iff (!presetn)
         (cap_bus.event_p && sync_mode == SRCS_SYNC_DIVRST) |=> div_reset;
   endproperty
   a_divrst: assert property (p_divrst) else $error("divider reset missing"); // R8

   property p_linkdn;
      @(posedge pclk) disable iff (!presetn)
         link_down |-> $past(cap_bus.phase) != 4'h0 && $past(sync_mode) == SRCS_SYNC_DIVRST;
   endproperty
   a_linkdn: assert property (p_linkdn) else $error("link drop without phase change"); // R9

   property p_tstamp_quiet;
      @(posedge pclk) disable iff (!presetn)
         $past(sync_mode) == SRCS_SYNC_TSTAMP |-> !div_reset && !link_down;
   endproperty
   a_tstamp_quiet: assert property (p_tstamp_quiet) else $error("timestamp mode disturbed"); // R10

   property p_flags_held;
      @(posedge pclk) disable iff (!presetn)
         flag_rst ##1 flag_rst |-> s_q.setup == 4'h0 && s_q.hold == 4'h0;
   endproperty
   a_flags_held: assert property (p_flags_held) else $error("flags not held"); // R12

   property p_ts_zero;
      @(posedge pclk) disable iff (!presetn)
         (cap_bus.event_p && sync_mode == SRCS_SYNC_TSTAMP && s_q.tsdly == 7'h00) |=> ts_ctrl_bit;
   endproperty
   a_ts_zero: assert property (p_ts_zero) else $error("undelayed mark missing"); // R11

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
         (s_q.irq_st[0] && s_q.irq_msk[0]) |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_pos_win;
      @(posedge pclk) disable iff (!presetn)
         (cap_bus.event_p && !cap_bus.phase[3]) |->
            !cap_bus.phase[0] && cap_bus.phase <= {1'b0, s_q.win[1:0], 1'b0};
   endproperty
   a_pos_win: assert property (p_pos_win) else $error("late capture outside window"); // R1

   property p_exact;
      @(posedge pclk) disable iff (!presetn)
         (cap_bus.event_p && s_q.win == 4'h0) |-> cap_bus.phase == 4'h0;
   endproperty
   a_exact: assert property (p_exact) else $error("skewed capture with zero windows"); // R1

   property p_neg_win;
      @(posedge pclk) disable iff (!presetn)
         (cap_bus.event_p && cap_bus.phase[3]) |->
            !cap_bus.phase[0] && (5'd16 - {1'b0, cap_bus.phase}) <= {2'b00, s_q.win[3:2], 1'b0};
   endproperty
   a_neg_win: assert property (p_neg_win) else $error("early capture outside window"); // R2

   property p_ts_delay1;
      @(posedge pclk) disable iff (!presetn)
         (cap_bus.event_p && sync_mode == SRCS_SYNC_TSTAMP && s_q.tsdly == 7'h01) |->
            ##2 ts_ctrl_bit;
   endproperty
   a_ts_delay1: assert property (p_ts_delay1) else $error("one-cycle mark delay wrong"); // R3

   property p_phase_rep;
      @(posedge pclk) disable iff (!presetn)
         cap_bus.event_p |=> s_q.phase == $past(cap_bus.phase);
   endproperty
   a_phase_rep: assert property (p_phase_rep) else $error("phase not reported"); // R4

   property p_phase_hold;
      @(posedge pclk) disable iff (!presetn) !cap_bus.event_p |=> $stable(s_q.phase);
   endproperty
   a_phase_hold: assert property (p_phase_hold) else $error("phase moved without capture"); // R4

   property p_count_hold;
      @(posedge pclk) disable iff (!presetn)
         (!cap_bus.event_p && !flag_rst) |=> $stable(s_q.count);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("counter moved without event"); // R5

   property p_divrst_src;
      @(posedge pclk) disable iff (!presetn)
         div_reset |-> $past(cap_bus.event_p) && $past(sync_mode) == SRCS_SYNC_DIVRST;
   endproperty
   a_divrst_src: assert property (p_divrst_src) else $error("divider reset without event"); // R8

   property p_link_with_rst;
      @(posedge pclk) disable iff (!presetn) link_down |-> div_reset;
   endproperty
   a_link_with_rst: assert property (p_link_with_rst) else $error("link drop alone"); // R9

   property p_margin_clean;
      @(posedge pclk) disable iff (!presetn)
         cap_bus.event_p |-> cap_bus.setup_st == 4'h0 && cap_bus.hold_st == 4'h0;
   endproperty
   a_margin_clean: assert property (p_margin_clean) else $error("margin on clean capture"); // R13

   property p_miss_flag;
      @(posedge pclk) disable iff (!presetn) (cap_bus.miss_p && !flag_rst) |=> s_q.irq_st[1];
   endproperty
   a_miss_flag: assert property (p_miss_flag) else $error("margin event lost"); // R13

   c_capture: cover property (@(posedge pclk) disable iff (!presetn) cap_bus.event_p);
   c_miss:    cover property (@(posedge pclk) disable iff (!presetn) cap_bus.miss_p);
   c_wrap:    cover property (@(posedge pclk) disable iff (!presetn)
                              cap_bus.event_p && s_q.count == 8'hFF);
   c_linkdn:  cover property (@(posedge pclk) disable iff (!presetn) link_down);
   c_mark:    cover property (@(posedge pclk) disable iff (!presetn) ts_ctrl_bit);
endmodule // srcs_top

// ---- verification/srcs_ref_gen.sv ----
// Behavioural clock generator: drives the reference pulse and the divider phase.
// Assumes fire is called right after a rising edge of pclk.
`timescale 1ns/1ps
module srcs_ref_gen (
   input  wire logic       pclk,
   output logic            sysref,
   output logic [3:0]      div_phase
);
   initial begin
      sysref    = 1'b0;
      div_phase = 4'h0;
   end
   // Phase settles before the pulse so both synchronisers see one consistent value
   task automatic fire(input logic [3:0] ph);
      div_phase <= ph;
      repeat (3) @(posedge pclk);
      sysref <= 1'b1;
      repeat (4) @(posedge pclk);
      sysref <= 1'b0;
      repeat (10) @(posedge pclk);
   endtask
endmodule // srcs_ref_gen

// ---- verification/srcs_top_tb.sv ----
// Self-checking bench for the capture block: APB master, reference model, pulse monitors.
// Assumes the generator model above and the register map of srcs_cfg.svh.
`timescale 1ns/1ps
`include "srcs_cfg.svh"
module srcs_top_tb;
   import srcs_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, sr_d;
   logic        sysref, div_reset, link_down, ts_ctrl_bit, irq, m_sync;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  div_phase, m_ph;
   logic [11:0] bt[8] = '{12'h200, 12'h210, 12'h630, 12'hC02, 12'hA02, 12'hA03, 12'h300, 12'h000};
   int          dl[4] = '{0, 1, 5, 127};
   int          n_errors, checked, cyc, n_dr, n_ld, t_rise, t_ts, m_cnt, m_dr, m_ld;
   // Pin rise to mark with no delay: two sync flops, edge register, mark register
   localparam int MARK_LAT = 4;
   srcs_top #(.TS_DEPTH(128)) srcs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sysref(sysref), .div_phase(div_phase),
      .div_reset(div_reset), .link_down(link_down), .ts_ctrl_bit(ts_ctrl_bit), .irq(irq));
   srcs_ref_gen srcs_ref_gen_inst (.pclk(pclk), .sysref(sysref), .div_phase(div_phase));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      sr_d <= sysref;
      if (sysref && !sr_d) t_rise = cyc;
      if (presetn) begin
         n_dr += int'(div_reset);
         n_ld += int'(link_down);
         if (ts_ctrl_bit) t_ts = cyc;
      end
      // Ceiling well above the roughly 6600 cycles the sequence needs
      if (cyc > 60000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input logic [11:0] idx, input logic [31:0] exp, input string nm);
      apb(1'b0, idx, 32'h0000_0000);
      chk(nm, rd, exp);
   endtask
   function automatic bit acc(input logic [3:0] ph, input logic [1:0] p, input logic [1:0] n);
      return !ph[0] && (ph <= 2 * p || 16 - ph <= 2 * n);
   endfunction
   task automatic ev(input logic [3:0] ph, input logic [1:0] p, input logic [1:0] n);
      apb(1'b1, `SRCS_IDX_CTRL3, {28'h000_0000, n, p});
      srcs_ref_gen_inst.fire(ph);
      if (acc(ph, p, n)) begin
         m_cnt = (m_cnt + 1) % 256;
         m_ph  = ph;
         if (!m_sync) m_dr++;
         if (!m_sync && ph != 4'h0) m_ld++;
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 16'h0000;
      pwdata  = 32'h0000_0000;
      m_ph    = 4'h0;
      m_sync  = 1'b0;
      void'($urandom(32'ha7c7_19c9));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (bt[i]) rchk(i < 7 ? 12'h120 + 12'(i % 4) : `SRCS_IDX_SYNCM, 0, "reset value");
      rchk(`SRCS_IDX_STAT3, 0, "count reset");
      apb(1'b1, `SRCS_IDX_TSDLY, 32'h0000_00ff);
      rchk(`SRCS_IDX_TSDLY, 32'h0000_007f, "delay width");
      apb(1'b1, `SRCS_IDX_STAT1, 32'h0000_00ff);
      rchk(`SRCS_IDX_STAT1, 0, "status read-only");
      rchk(12'h125, 0, "unmapped read");
      chk("unmapped error", er, 1);
      $display("register test done");
      apb(1'b1, `SRCS_IDX_CTRL1, 32'h0000_0002);
      foreach (bt[i]) ev(bt[i][11:8], bt[i][5:4], bt[i][1:0]);
      repeat (24) ev(4'($urandom_range(15)), 2'($urandom_range(3)), 2'($urandom_range(3)));
      ev(4'h2, 2'd1, 2'd0);
      apb(1'b1, `SRCS_IDX_CTRL1, 32'h0000_0000);
      rchk(`SRCS_IDX_STAT3, m_cnt, "event count");
      rchk(`SRCS_IDX_STAT2, m_ph, "divider phase");
      chk("divider resets", n_dr, m_dr);
      chk("link drops", n_ld, m_ld);
      $display("capture window test done");
      apb(1'b1, `SRCS_IDX_SYNCM, 32'h0000_0001);
      m_sync = 1'b1;
      apb(1'b1, `SRCS_IDX_CTRL1, 32'h0000_0002);
      foreach (dl[i]) begin
         apb(1'b1, `SRCS_IDX_TSDLY, dl[i]);
         t_ts = 0;
         ev(4'h0, 2'd0, 2'd0);
         repeat (140) @(posedge pclk);
         chk("mark latency", t_ts - t_rise, MARK_LAT + dl[i]);
      end
      chk("no divider reset", n_dr, m_dr);
      chk("no link drop", n_ld, m_ld);
      $display("timestamp test done");
      apb(1'b1, `SRCS_IDX_IRQST, 32'h0000_0003);
      apb(1'b1, `SRCS_IDX_IRQMSK, 32'h0000_0001);
      chk("irq idle", irq, 0);
      ev(4'h0, 2'd0, 2'd0);
      chk("irq raised", irq, 1);
      apb(1'b1, `SRCS_IDX_IRQMSK, 32'h0000_0000);
      chk("irq masked", irq, 0);
      apb(1'b1, `SRCS_IDX_IRQMSK, 32'h0000_0001);
      apb(1'b1, `SRCS_IDX_IRQST, 32'h0000_0001);
      chk("irq cleared", irq, 0);
      $display("interrupt test done");
      ev(4'h3, 2'd0, 2'd0);
      rchk(`SRCS_IDX_STAT1, 32'h0000_0030, "hold margin");
      rchk(`SRCS_IDX_IRQST, 32'h0000_0002, "margin event");
      apb(1'b1, `SRCS_IDX_CTRL1, 32'h0000_0040);
      m_cnt = 0;
      rchk(`SRCS_IDX_STAT1, 0, "flags held");
      rchk(`SRCS_IDX_STAT3, 0, "count cleared");
      apb(1'b1, `SRCS_IDX_CTRL1, 32'h0000_0002);
      // Long run of clean captures to pass the wrap point
      repeat (257) ev(4'h0, 2'd0, 2'd0);
      apb(1'b1, `SRCS_IDX_CTRL1, 32'h0000_0000);
      rchk(`SRCS_IDX_STAT3, m_cnt, "count wrap");
      $display("flag reset and wrap test done");
      tally_and_finish();
   end
endmodule // srcs_top_tb
